//--- core/wdcm_pkg.sv
// Constants and types shared by the windowed watchdog and clock monitor
package wdcm_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 200_000_000;
	// Instruction clock slower than one tick per this time is flagged
	localparam int unsigned CM_SLOW_US    = 1000;
	localparam int unsigned CM_SLOW_CYC   = (CLK_HZ / 1_000_000) * CM_SLOW_US;
	localparam logic [16:0] LOWER_LIMIT   = 17'h00100;
	localparam logic [16:0] UPPER_BASE    = 17'h02000;
	localparam logic [4:0]  RELEASE_TICKS = 5'h10;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_SERVICE  = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h01;
	localparam int         OPT_WD_BIT   = 2;
	localparam logic [4:0] SERVICE_KEY  = 5'h0c;
	localparam logic [1:0] WIN_RESET    = 2'h3;
	localparam logic       CM_EN_RESET  = 1'b1;

	typedef struct packed {
		logic [1:0] win;
		logic [4:0] key;
		logic       cm_en;
	} wdcm_service_t;

	typedef struct packed {
		logic [2:0] zero;
		logic       wd_enabled;
		logic       configured;
		logic       wd_fault;
		logic       cm_fault;
		logic       pin_level;
	} wdcm_status_t;

	// ------------------------------------------------------------
	// Watchdog states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_BOOT  = 5'b00001,
		ST_RUN   = 5'b00010,
		ST_DRIVE = 5'b00100,
		ST_HOLD  = 5'b01000,
		ST_REL   = 5'b10000
	} wdcm_state_t;

endpackage : wdcm_pkg

//--- core/wdcm_watchdog.sv
// Windowed watchdog with clock monitor driving one shared fault pin
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module wdcm_watchdog
	import wdcm_pkg::*;
#(
	parameter int unsigned CM_LIMIT = CM_SLOW_CYC
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// Core status
	input  wire logic       i_instr_tick,
	input  wire logic       i_halt,
	input  wire logic       i_idle,
	input  wire logic [7:0] i_option_config_reg,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output var  logic [7:0] o_rdata,
	// Fault pin on port G pin one
	input  wire logic       i_fault_out,
	output var  logic       o_fault_out,
	output var  logic       o_fault_out_oe,
	output var  logic       o_fault_pullup_en,
	output var  logic       o_port_g_pin_one_is_fault
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wdcm_state_t   state;
	wdcm_state_t   next_state;
	wdcm_service_t stored;
	wdcm_service_t wr_svc;
	wdcm_status_t  status;
	logic          configured;
	logic [16:0]   win_cnt;
	logic [4:0]    rel_cnt;
	logic [31:0]   cm_cnt;
	logic          cm_slow;
	logic [4:0]    cm_rel_cnt;
	logic          cm_fault;

	wire wd_en       = ~i_option_config_reg[OPT_WD_BIT];
	wire sel_service = (i_addr == OFF_SERVICE);
	wire sel_status  = (i_addr == OFF_STATUS);
	wire svc_wr      = i_wr && sel_service;
	wire wd_frozen   = i_halt || i_idle;
	wire wd_tick     = i_instr_tick && !wd_frozen;

	assign wr_svc = wdcm_service_t'(i_wdata);

	wire key_bad     = (wr_svc.key != SERVICE_KEY);
	wire win_bad     = configured && (wr_svc.win != stored.win);
	wire cm_bad      = configured && (wr_svc.cm_en != stored.cm_en);
	wire too_early   = configured && (win_cnt < LOWER_LIMIT);
	wire svc_error   = key_bad || win_bad || cm_bad || too_early;

	// Upper limit doubles per select step
	wire [16:0] upper_lim = UPPER_BASE << stored.win;
	wire timeout     = (win_cnt >= upper_lim);

	// Services only count in the run state
	wire svc_take    = svc_wr && (state == ST_RUN) && wd_en;
	wire svc_ok      = svc_take && !svc_error;
	wire wd_trip     = wd_en && (state == ST_RUN)
	                   && ((svc_take && svc_error) || timeout);
	wire wd_driving  = (state == ST_DRIVE) || (state == ST_HOLD);
	wire hold_done   = (state == ST_HOLD) && i_instr_tick && (rel_cnt == RELEASE_TICKS - 5'h01);

	// ------------------------------------------------------------
	// Watchdog state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_BOOT: begin
				// Pin found low straight after reset is timed out
				next_state = (i_fault_out || !wd_en) ? ST_RUN : ST_HOLD;
			end
			ST_RUN: begin
				if (wd_trip) begin
					next_state = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (!i_fault_out) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (hold_done) begin
					next_state = ST_REL;
				end
			end
			ST_REL: begin
				if (i_fault_out) begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Stored choices, fixed after the first good write
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			stored.win   <= WIN_RESET;
			stored.key   <= 5'h00;
			stored.cm_en <= CM_EN_RESET;
			configured   <= 1'b0;
		end else if (svc_ok && !configured) begin
			stored.win   <= wr_svc.win;
			stored.cm_en <= wr_svc.cm_en;
			configured   <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Service window counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || state != ST_RUN || svc_ok) begin
			// Restart on valid service, including the configuring one
			win_cnt <= 17'h00000;
		end else if (wd_tick && !timeout) begin
			win_cnt <= win_cnt + 17'h00001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || state != ST_HOLD) begin
			rel_cnt <= 5'h00;
		end else if (i_instr_tick) begin
			rel_cnt <= rel_cnt + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Clock monitor
	// ------------------------------------------------------------
	// Threshold sits between the 10 kHz and 10 Hz periods
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_instr_tick) begin
			cm_cnt <= 32'h00000000;
		end else if (!cm_slow) begin
			cm_cnt <= cm_cnt + 32'h00000001;
		end
	end

	assign cm_slow = (cm_cnt >= CM_LIMIT);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cm_fault   <= 1'b0;
			cm_rel_cnt <= 5'h00;
		end else if (stored.cm_en && cm_slow) begin
			// Enabled from reset, so a dead oscillator trips here
			cm_fault   <= 1'b1;
			cm_rel_cnt <= 5'h00;
		end else if (cm_fault && i_instr_tick) begin
			cm_rel_cnt <= cm_rel_cnt + 5'h01;
			if (cm_rel_cnt == RELEASE_TICKS - 5'h01) begin
				cm_fault <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin and register outputs
	// ------------------------------------------------------------
	assign o_fault_out               = 1'b0;
	assign o_fault_out_oe            = wd_en && (wd_driving || cm_fault);
	assign o_fault_pullup_en         = wd_en;
	assign o_port_g_pin_one_is_fault = wd_en;

	assign status.zero       = 3'h0;
	assign status.wd_enabled = wd_en;
	assign status.configured = configured;
	assign status.wd_fault   = wd_driving;
	assign status.cm_fault   = cm_fault;
	assign status.pin_level  = i_fault_out;

	// Key never reads back
	wire [7:0] svc_read   = {stored.win, 5'h00, stored.cm_en};
	wire [7:0] next_rdata = sel_service ? svc_read :
	                        sel_status  ? 8'(status) : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	reset_quiet_a: assert property (
		$past(i_sys_rst) |-> !o_fault_out_oe)
		else $error("fault driven straight after reset");

	reset_config_a: assert property (
		$fell(i_sys_rst) |-> stored.win == 2'h3 && stored.cm_en && !configured)
		else $error("bad state after reset");

	bad_key_a: assert property (
		svc_wr && state == ST_RUN && wd_en && key_bad |=> state == ST_DRIVE)
		else $error("bad key not flagged");

	early_svc_a: assert property (
		svc_wr && state == ST_RUN && wd_en && configured && win_cnt < 17'h00100
		|=> state == ST_DRIVE)
		else $error("early service not flagged");

	lock_choice_a: assert property (
		configured |=> $stable(stored.win) && $stable(stored.cm_en))
		else $error("stored choice changed");

	good_restart_a: assert property (
		svc_ok |=> win_cnt == 17'h00000 && state == ST_RUN)
		else $error("valid service did not restart");

	ignore_fault_a: assert property (
		svc_wr && wd_driving |=> $stable(configured) && win_cnt == 17'h00000)
		else $error("service during fault took effect");

	upper_trip_a: assert property (
		state == ST_RUN && wd_en && win_cnt >= upper_lim |=> state == ST_DRIVE)
		else $error("timeout not flagged");

	hold_len_a: assert property (
		$rose(state == ST_HOLD) |-> o_fault_out_oe || !wd_en)
		else $error("pin released too early");

	drive_shared_a: assert property (
		wd_en && cm_fault |-> o_fault_out_oe)
		else $error("clock fault not on pin");

	key_hidden_a: assert property (
		i_rd && sel_service |=> o_rdata[5:1] == 5'h00)
		else $error("key read back");

	cm_trip_a: assert property (
		stored.cm_en && cm_slow |=> cm_fault)
		else $error("slow clock not flagged");

	cov_config: cover property (svc_ok && !configured);
	cov_timeout: cover property (state == ST_RUN && timeout && wd_en);
	cov_release: cover property (state == ST_REL ##1 state == ST_RUN);
	cov_cm: cover property ($fell(cm_fault));
	cov_freeze: cover property (state == ST_RUN && wd_frozen);

	// ------------------------------------------------------------
	// Pin handshake, freeze, clock monitor and service checks
	// ------------------------------------------------------------
	freeze_hold_a: assert property (
		state == ST_RUN && wd_frozen && !svc_wr
		|=> win_cnt == $past(win_cnt))
		else $error("window counted while frozen");

	boot_low_a: assert property (
		state == ST_BOOT && wd_en && !i_fault_out
		|=> state == ST_HOLD)
		else $error("low pin at boot not timed out");

	boot_high_a: assert property (
		state == ST_BOOT && i_fault_out
		|=> state == ST_RUN)
		else $error("high pin at boot did not arm");

	rel_restart_a: assert property (
		state == ST_REL && i_fault_out
		|=> state == ST_RUN && win_cnt == 17'h00000)
		else $error("window not restarted on pin high");

	off_quiet_a: assert property (
		!wd_en
		|-> !o_fault_out_oe && !o_fault_pullup_en)
		else $error("disabled watchdog touched pin");

	cm_off_a: assert property (
		!stored.cm_en && !cm_fault
		|=> !cm_fault)
		else $error("disabled monitor flagged");

	hold_done_a: assert property (
		hold_done
		|=> state == ST_REL && !wd_driving)
		else $error("pin not released after hold");

	drive_wait_a: assert property (
		state == ST_DRIVE && i_fault_out
		|=> state == ST_DRIVE)
		else $error("drive ended before pin fell");

	first_svc_a: assert property (
		svc_ok && !configured
		|=> configured && win_cnt == 17'h00000)
		else $error("first service not counted");

	cm_release_a: assert property (
		cm_fault && !cm_slow && i_instr_tick && cm_rel_cnt == RELEASE_TICKS - 5'h01
		|=> !cm_fault)
		else $error("monitor fault not released");

	cm_hold_a: assert property (
		cm_fault && cm_slow
		|=> cm_fault)
		else $error("monitor fault dropped while slow");

	win_mismatch_a: assert property (
		svc_take && configured && win_bad
		|=> state == ST_DRIVE)
		else $error("window mismatch not flagged");

	cm_mismatch_a: assert property (
		svc_take && configured && cm_bad
		|=> state == ST_DRIVE)
		else $error("monitor select mismatch not flagged");

endmodule : wdcm_watchdog
`default_nettype wire

//--- sim/wdcm_pin_model.sv
// Fault pin wire with weak pull-up and an outside party that may hold it low
`timescale 1ns/1ps
`default_nettype none
module wdcm_pin_model (
	// Clock
	input  wire logic i_clk,
	// Pin parties
	input  wire logic i_drive_low,
	input  wire logic i_pullup_en,
	input  wire logic i_force_low,
	// Wire level
	output var  logic o_pin
);
	logic toggle = 1'b0;

	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// Undriven without pull-up the level wanders, so never trust it
	always_ff @(posedge i_clk) begin
		toggle <= ~toggle;
	end
	assign o_pin = (i_drive_low | i_force_low) ? 1'b0 : (i_pullup_en ? 1'b1 : toggle);
endmodule : wdcm_pin_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the windowed watchdog and clock monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
	import wdcm_pkg::*;
;
	localparam int CM_SIM = 64;
	logic       i_clk, i_sys_rst, i_wr, i_rd, tick_en, force_low, pin;
	logic       i_instr_tick = 1'b0;
	logic [1:0] frz = 2'b00;
	logic       o_fault_out, o_fault_out_oe, o_fault_pullup_en, o_port_g_pin_one_is_fault;
	logic [7:0] i_addr, i_wdata, i_option_config_reg, o_rdata;
	int         fails = 0, checks = 0, ticks = 0, cyc = 0, t0;
	logic [7:0] bad [3] = '{8'h19, 8'h58, 8'h1a};

	wdcm_watchdog #(.CM_LIMIT(CM_SIM)) u_dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr_tick(i_instr_tick),
		.i_halt(frz[0]), .i_idle(frz[1]), .i_option_config_reg(i_option_config_reg),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_fault_out(pin), .o_fault_out(o_fault_out), .o_fault_out_oe(o_fault_out_oe),
		.o_fault_pullup_en(o_fault_pullup_en),
		.o_port_g_pin_one_is_fault(o_port_g_pin_one_is_fault)
	);
	wdcm_pin_model u_pin (
		.i_clk(i_clk), .i_drive_low(o_fault_out_oe), .i_pullup_en(o_fault_pullup_en),
		.i_force_low(force_low), .o_pin(pin)
	);

	// ------------------------------------------------------------
	// Clock, instruction ticks, hang limit
	// ------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// One tick every two clocks keeps the 8k window short
	always @(posedge i_clk) begin
		i_instr_tick <= tick_en & ~i_instr_tick;
		if (i_instr_tick)
			ticks <= ticks + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task stop_test();
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task in_range(input int v, input int lo, input int hi);
		checks++;
		if (v < lo || v > hi) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, v, lo);
		end
	endtask : in_range
	task do_reset();
		i_sys_rst <= 1'b1;
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : do_reset
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		cmp(o_rdata, exp);
	endtask : rd
	task wait_oe(input logic v, input int lim);
		int n;
		n = 0;
		#1;
		while (o_fault_out_oe !== v && n < lim) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		cmp({7'h0, o_fault_out_oe}, {7'h0, v});
	endtask : wait_oe
	task wait_ticks(input int n);
		repeat (n) @(posedge i_clk iff i_instr_tick);
	endtask : wait_ticks

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_sys_rst, i_wr, i_rd, force_low} = 4'h8;
		{i_addr, i_wdata, i_option_config_reg} = 24'h0;
		tick_en = 1'b1;
		do_reset();
		rd(OFF_SERVICE, 8'hc1);
		rd(OFF_STATUS, 8'h11);
		rd(8'h7f, 8'h00);
		wr(OFF_SERVICE, 8'h18);
		rd(OFF_SERVICE, 8'h00);
		wait_ticks(300);
		wr(OFF_SERVICE, 8'h18);
		repeat (20) @(posedge i_clk);
		cmp({7'h0, o_fault_out_oe}, 8'h00);
		wr(OFF_SERVICE, 8'h18);
		wait_oe(1'b1, 4);
		cmp({7'h0, o_fault_out}, 8'h00);
		t0 = ticks;
		wr(OFF_SERVICE, 8'h18);
		wait_oe(1'b0, 200);
		in_range(ticks - t0, 16, 33);
		// Each later field mismatch, one at a time
		foreach (bad[i]) begin
			wait_ticks(300);
			wr(OFF_SERVICE, bad[i]);
			wait_oe(1'b1, 4);
			wait_oe(1'b0, 200);
		end
		// Frozen window must still look young after 300 ticks
		@(posedge i_clk);
		frz <= 2'b01;
		wait_ticks(150);
		frz <= 2'b10;
		wait_ticks(150);
		frz <= 2'b00;
		wr(OFF_SERVICE, 8'h18);
		wait_oe(1'b1, 4);
		wait_oe(1'b0, 200);
		t0 = ticks;
		wait_oe(1'b1, 20000);
		in_range(ticks - t0, 8190, 8194);
		wait_oe(1'b0, 200);
		do_reset();
		wr(OFF_SERVICE, 8'h00);
		wait_oe(1'b1, 4);
		wait_oe(1'b0, 200);
		tick_en = 1'b0;
		do_reset();
		wait_oe(1'b1, CM_SIM + 8);
		rd(OFF_STATUS, 8'h12);
		tick_en = 1'b1;
		wait_oe(1'b0, 200);
		i_option_config_reg <= 8'h04;
		do_reset();
		wr(OFF_SERVICE, 8'h00);
		repeat (8) @(posedge i_clk);
		cmp({6'h0, o_fault_pullup_en, o_port_g_pin_one_is_fault}, 8'h00);
		cmp({7'h0, o_fault_out_oe}, 8'h00);
		i_option_config_reg <= 8'h00;
		force_low <= 1'b1;
		do_reset();
		force_low <= 1'b0;
		wait_oe(1'b1, 2);
		wait_oe(1'b0, 200);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
